/* File: design/spb_pkg.sv */
// serial port control and buffer: shared constants
// assumes a single 20 MHz clock and an 8-bit register port
// Functional notes
// - bit 7 of the control register is either the high mode bit or the framing-error flag, picked by error_flag_select.
// - as the framing-error flag, bit 7 is set on an invalid stop bit and stays set until software clears it.
// - mode 00 is synchronous, 8 bits per frame, bit period 6 clocks (6T or filter bit set) or 12 clocks (12T with filter bit clear).
// - mode 01 is asynchronous with a 10-bit frame at the variable baud rate.
// - mode 10 is asynchronous with an 11-bit frame at 32/16 clocks (6T) or 64/32 clocks (12T) per bit.
// - mode 11 is asynchronous with an 11-bit frame at the variable baud rate.
// - in modes 2 and 3 with the filter bit set, receive-done is not raised when the received ninth bit is 0.
// - in mode 1 with the filter bit set, receive-done stays low when the stop bit is invalid.
// - in mode 0 the filter bit picks the shift clock; when clear the port runs at one twelfth of the clock in 12T and one sixth in 6T.
// - the receive-enable bit 4 allows reception when 1 and blocks it when 0.
// - in modes 2 and 3 the transmit ninth bit is sent as the ninth bit; only software changes it.
// - the received ninth bit holds the ninth data bit in modes 2/3, the stop bit in mode 1 with filter clear, nothing in mode 0.
// - transmit-done is set at the end of bit 8 in mode 0 and at the start of the stop bit in modes 1-3; software clears it.
// - receive-done is set at the end of bit 8 in mode 0 and mid stop bit in modes 1-3, subject to the filter; software clears it.
// - the data window holds a receive register for reads and a transmit buffer for writes.
package spb_pkg;
   localparam logic [7:0] SPB_ADDR_CTRL = 8'h98;
   localparam logic [7:0] SPB_ADDR_DATA = 8'h99;
   localparam logic [7:0] SPB_ADDR_AUX  = 8'h9A;
   localparam logic [7:0] SPB_ADDR_STAT = 8'h9B;
   localparam logic [7:0] SPB_ADDR_MASK = 8'h9C;
   localparam int SPB_B_M0  = 7;
   localparam int SPB_B_M1  = 6;
   localparam int SPB_B_SM2 = 5;
   localparam int SPB_B_REN = 4;
   localparam int SPB_B_TB8 = 3;
   localparam int SPB_B_RB8 = 2;
   localparam int SPB_B_TI  = 1;
   localparam int SPB_B_RI  = 0;
   localparam int SPB_A_SEL = 0;
   localparam int SPB_A_T6  = 1;
   localparam int SPB_A_DBL = 2;
   localparam logic [7:0] SPB_CTRL_RST = 8'h00;
   localparam logic [7:0] SPB_AUX_RST  = 8'h00;
   localparam logic [2:0] SPB_EV_W     = 3'h0;
   localparam int SPB_CLK_MHZ = 20;
   localparam int SPB_M0_DIV_12T = 12;
   localparam int SPB_M0_DIV_6T  = 6;
   localparam int SPB_M2_DIV_12T = 64;
   localparam int SPB_M2_DIV_6T  = 32;
   localparam int SPB_SAMPLES = 16;
   typedef enum logic [1:0] {
      SPB_MODE0 = 2'h0,
      SPB_MODE1 = 2'h1,
      SPB_MODE2 = 2'h2,
      SPB_MODE3 = 2'h3
   } spb_mode_t;
endpackage

/* File: design/spb_divider.sv */
// bit-tick divider: one pulse every div_i enabled clocks
// assumes div_i is at least 1
`timescale 1ns/10ps
`default_nettype none
module spb_divider
   import spb_pkg::*;
#(
   parameter int W = 8
) (
   input  wire logic         mclk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   input  wire logic         clr_i,
   input  wire logic [W-1:0] div_i,
   output logic              tick_o
);
   logic [W-1:0] cnt_reg;
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (ce_i) begin
         if (clr_i || cnt_reg >= div_i - W'(1)) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + W'(1);
         end
      end
   end
   assign tick_o = ce_i && !clr_i && (cnt_reg >= div_i - W'(1));
endmodule
`default_nettype wire

/* File: design/spb_core.sv */
// serial port: control register, data window, tx and rx engines
// assumes synchronous pins and an external baud tick for modes 1 and 3
//
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module spb_core
   import spb_pkg::*;
(
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [7:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   input  wire logic       baud_tick_i,
   input  wire logic       rxd_i,
   output logic            rxd_o,
   output logic            rxd_oe_o,
   output logic            txd_o,
   output logic            irq_o
);
   logic [7:0] ctrl_reg;
   logic [7:0] aux_reg;
   logic [7:0] rxbuf_reg;
   logic       fe_reg;
   logic       m0hi_reg;
   logic [2:0] stat_reg;
   logic [2:0] mask_reg;
   logic [7:0] rdata_reg;
   logic [1:0] mode;
   logic       ti_set, ri_set, fe_set, rb8_set, rb8_val;
   logic       wr_ctrl, wr_data;

   assign wr_ctrl = wr_i && addr_i == SPB_ADDR_CTRL;
   assign wr_data = wr_i && addr_i == SPB_ADDR_DATA;
   assign mode    = {m0hi_reg, ctrl_reg[SPB_B_M1]};

   // bit 7 store: routed by error_flag_select
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         m0hi_reg <= 1'b0;
         fe_reg   <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl && !aux_reg[SPB_A_SEL]) begin
            m0hi_reg <= wdata_i[SPB_B_M0];
         end
         if (fe_set) begin
            fe_reg <= 1'b1;
         end else if (wr_ctrl && aux_reg[SPB_A_SEL]) begin
            fe_reg <= wdata_i[SPB_B_M0];
         end
      end
   end

   // control bits 6..0, hardware sets win over software writes
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_reg <= SPB_CTRL_RST;
      end else if (ce_i) begin
         if (wr_ctrl) begin
            ctrl_reg[6:0] <= wdata_i[6:0];
         end
         if (ti_set) begin
            ctrl_reg[SPB_B_TI] <= 1'b1;
         end
         if (ri_set) begin
            ctrl_reg[SPB_B_RI] <= 1'b1;
         end
         if (rb8_set) begin
            ctrl_reg[SPB_B_RB8] <= rb8_val;
         end
      end
   end

   // aux: error select, 6T, double rate; mask and sticky status
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         aux_reg  <= SPB_AUX_RST;
         mask_reg <= SPB_EV_W;
         stat_reg <= SPB_EV_W;
      end else if (ce_i) begin
         if (wr_i && addr_i == SPB_ADDR_AUX) begin
            aux_reg <= wdata_i;
         end
         if (wr_i && addr_i == SPB_ADDR_MASK) begin
            mask_reg <= wdata_i[2:0];
         end
         stat_reg <= (stat_reg & ~((wr_i && addr_i == SPB_ADDR_STAT) ? wdata_i[2:0] : SPB_EV_W))
                     | {fe_set, ri_set, ti_set};
      end
   end
   assign irq_o = |(stat_reg & mask_reg);

   // read port, data one cycle after the strobe
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_reg <= 8'h00;
      end else if (ce_i) begin
         rdata_reg <= 8'h00;
         if (rd_i) begin
            case (addr_i)
               SPB_ADDR_CTRL: rdata_reg <= {aux_reg[SPB_A_SEL] ? fe_reg : m0hi_reg, ctrl_reg[6:0]};
               SPB_ADDR_DATA: rdata_reg <= rxbuf_reg;
               SPB_ADDR_AUX:  rdata_reg <= aux_reg;
               SPB_ADDR_STAT: rdata_reg <= {5'h00, stat_reg};
               SPB_ADDR_MASK: rdata_reg <= {5'h00, mask_reg};
               default:       rdata_reg <= 8'h00;
            endcase
         end
      end
   end
   assign rdata_o = rdata_reg;

   // bit-period divider: mode 0 and mode 2 fixed rates
   logic [6:0] div_val;
   logic       fix_tick, tick;
   logic       busy_any;
   always_comb begin
      if (mode == SPB_MODE0) begin
         // filter bit clear gives 1/12 (1/6 with the 6T bit), set gives the fast 6T rate
         div_val = (ctrl_reg[SPB_B_SM2] || aux_reg[SPB_A_T6]) ? 7'(SPB_M0_DIV_6T) : 7'(SPB_M0_DIV_12T);
      end else begin
         div_val = aux_reg[SPB_A_T6] ? (aux_reg[SPB_A_DBL] ? 7'(SPB_M2_DIV_6T / 2) : 7'(SPB_M2_DIV_6T))
                 : (aux_reg[SPB_A_DBL] ? 7'(SPB_M2_DIV_12T / 2) : 7'(SPB_M2_DIV_12T));
         div_val = mode == SPB_MODE2 ? 7'(int'(div_val) / SPB_SAMPLES) : 7'h01;
      end
   end
   spb_divider #(.W(7)) u_div (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .clr_i  (!busy_any),
      .div_i  (div_val),
      .tick_o (fix_tick)
   );
   // modes 1/3 use 16x sample tick from the baud input, mode 2 the divided one
   assign tick = (mode == SPB_MODE1 || mode == SPB_MODE3) ? baud_tick_i : fix_tick;

   // transmitter
   typedef enum logic [2:0] {
      SPB_TX_IDLE = 3'b001,
      SPB_TX_SHIFT = 3'b010,
      SPB_TX_STOP = 3'b100
   } spb_tx_t;
   spb_tx_t    tx_state_reg;
   logic [8:0] tx_sh_reg;
   logic [3:0] tx_cnt_reg;
   logic [3:0] tx_sub_reg;
   logic       txd_reg;
   logic [3:0] nbits;
   logic [3:0] tx_last;
   logic       tx_step;
   assign nbits   = (mode == SPB_MODE2 || mode == SPB_MODE3) ? 4'h9 : 4'h8;
   // mode 0 shows bit 0 at the write, so its last step ends the eighth bit
   assign tx_last = mode == SPB_MODE0 ? 4'h7 : nbits;
   assign tx_step = tick && (mode == SPB_MODE0 || tx_sub_reg == 4'hF);
   assign ti_set  = ce_i && tx_step && tx_state_reg == SPB_TX_SHIFT && tx_cnt_reg == tx_last;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_state_reg <= SPB_TX_IDLE;
         tx_sh_reg    <= 9'h1FF;
         tx_cnt_reg   <= 4'h0;
         tx_sub_reg   <= 4'h0;
         txd_reg      <= 1'b1;
      end else if (ce_i) begin
         if (tick && mode != SPB_MODE0) begin
            tx_sub_reg <= tx_sub_reg + 4'h1;
         end
         case (tx_state_reg)
            SPB_TX_IDLE: begin
               if (wr_data) begin
                  tx_sh_reg    <= {ctrl_reg[SPB_B_TB8], wdata_i};
                  tx_cnt_reg   <= 4'h0;
                  tx_sub_reg   <= 4'h0;
                  txd_reg      <= mode == SPB_MODE0 ? wdata_i[0] : 1'b0;
                  tx_state_reg <= SPB_TX_SHIFT;
               end
            end
            SPB_TX_SHIFT: begin
               if (tx_step) begin
                  if (tx_cnt_reg == tx_last) begin
                     txd_reg      <= 1'b1;
                     tx_state_reg <= mode == SPB_MODE0 ? SPB_TX_IDLE : SPB_TX_STOP;
                  end else begin
                     txd_reg    <= mode == SPB_MODE0 ? tx_sh_reg[1] : tx_sh_reg[0];
                     tx_sh_reg  <= {1'b1, tx_sh_reg[8:1]};
                     tx_cnt_reg <= tx_cnt_reg + 4'h1;
                  end
               end
            end
            SPB_TX_STOP: begin
               if (tx_step) begin
                  tx_state_reg <= SPB_TX_IDLE;
               end
            end
            default: tx_state_reg <= SPB_TX_IDLE;
         endcase
      end
   end
   assign txd_o = txd_reg;

   // receiver
   typedef enum logic [2:0] {
      SPB_RX_IDLE = 3'b001,
      SPB_RX_DATA = 3'b010,
      SPB_RX_STOP = 3'b100
   } spb_rx_t;
   spb_rx_t    rx_state_reg;
   logic [8:0] rx_sh_reg;
   logic [3:0] rx_cnt_reg;
   logic [3:0] rx_sub_reg;
   logic       rxd_prev_reg;
   logic       rx_mid, rx_fin, stop_ok, keep;
   assign rx_mid  = tick && (mode == SPB_MODE0 || rx_sub_reg == 4'h7);
   assign rx_fin  = ce_i && rx_state_reg == SPB_RX_STOP && rx_mid;
   assign stop_ok = rxd_i;
   always_comb begin
      keep = 1'b1;
      if (ctrl_reg[SPB_B_SM2] && (mode == SPB_MODE2 || mode == SPB_MODE3)) begin
         keep = rx_sh_reg[8];
      end else if (ctrl_reg[SPB_B_SM2] && mode == SPB_MODE1) begin
         keep = stop_ok;
      end
   end
   assign ri_set  = (rx_fin && keep) ||
                    (ce_i && mode == SPB_MODE0 && rx_state_reg == SPB_RX_DATA && rx_mid && rx_cnt_reg == 4'h7);
   assign fe_set  = rx_fin && !stop_ok;
   assign rb8_set = rx_fin && keep && mode != SPB_MODE0 && !(mode == SPB_MODE1 && ctrl_reg[SPB_B_SM2]);
   assign rb8_val = mode == SPB_MODE1 ? stop_ok : rx_sh_reg[8];
   assign busy_any = tx_state_reg != SPB_TX_IDLE || rx_state_reg != SPB_RX_IDLE;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_state_reg <= SPB_RX_IDLE;
         rx_sh_reg    <= 9'h000;
         rx_cnt_reg   <= 4'h0;
         rx_sub_reg   <= 4'h0;
         rxbuf_reg    <= 8'h00;
         rxd_prev_reg <= 1'b1;
      end else if (ce_i) begin
         rxd_prev_reg <= rxd_i;
         if (tick && mode != SPB_MODE0) begin
            rx_sub_reg <= rx_sub_reg + 4'h1;
         end
         case (rx_state_reg)
            SPB_RX_IDLE: begin
               if (ctrl_reg[SPB_B_REN]) begin
                  if (mode == SPB_MODE0 && !ctrl_reg[SPB_B_RI] && !wr_ctrl) begin
                     rx_state_reg <= SPB_RX_DATA;
                     rx_cnt_reg   <= 4'h0;
                  // start needs a falling edge: a line held low after a bad stop bit must not refire
                  end else if (mode != SPB_MODE0 && rxd_prev_reg && !rxd_i) begin
                     rx_state_reg <= SPB_RX_DATA;
                     rx_cnt_reg   <= 4'h0;
                     rx_sub_reg   <= 4'h0;
                  end
               end
            end
            SPB_RX_DATA: begin
               if (rx_mid) begin
                  rx_sh_reg  <= {rxd_i, rx_sh_reg[8:1]};
                  rx_cnt_reg <= rx_cnt_reg + 4'h1;
                  if (mode == SPB_MODE0 && rx_cnt_reg == 4'h7) begin
                     rxbuf_reg    <= {rxd_i, rx_sh_reg[8:2]};
                     rx_state_reg <= SPB_RX_IDLE;
                  end else if (mode != SPB_MODE0 && rx_cnt_reg == 4'h0 && rxd_i) begin
                     rx_state_reg <= SPB_RX_IDLE;
                  end else if (mode != SPB_MODE0 && rx_cnt_reg == nbits) begin
                     rx_state_reg <= SPB_RX_STOP;
                  end
               end
            end
            SPB_RX_STOP: begin
               if (rx_mid) begin
                  if (keep) begin
                     rxbuf_reg <= nbits == 4'h9 ? rx_sh_reg[7:0] : rx_sh_reg[8:1];
                  end
                  rx_state_reg <= SPB_RX_IDLE;
               end
            end
            default: rx_state_reg <= SPB_RX_IDLE;
         endcase
      end
   end
   // mode 0 drives the clock-shift data line only when transmitting
   assign rxd_o    = txd_reg;
   assign rxd_oe_o = mode == SPB_MODE0 && tx_state_reg == SPB_TX_SHIFT;

   AST_TI_SET: assert property (@(posedge mclk_i) disable iff (rst_i)
      ti_set |=> ctrl_reg[SPB_B_TI]) else $error("transmit done not set");
   AST_RI_FILTER: assert property (@(posedge mclk_i) disable iff (rst_i)
      rx_fin && ctrl_reg[SPB_B_SM2] && (mode == SPB_MODE2 || mode == SPB_MODE3) && !rx_sh_reg[8]
      && !ctrl_reg[SPB_B_RI] && !wr_ctrl
      |=> !ctrl_reg[SPB_B_RI]) else $error("filtered frame raised receive done");
   AST_FE_STICKY: assert property (@(posedge mclk_i) disable iff (rst_i)
      fe_set |=> fe_reg) else $error("frame error not set");
   AST_NO_REN: assert property (@(posedge mclk_i) disable iff (rst_i)
      rx_state_reg == SPB_RX_IDLE && !ctrl_reg[SPB_B_REN] |=> rx_state_reg == SPB_RX_IDLE)
      else $error("reception while disabled");
   AST_TX_START: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_i && wr_data && tx_state_reg == SPB_TX_IDLE |=> tx_state_reg == SPB_TX_SHIFT)
      else $error("write did not start frame");
   AST_RB8_STOP: assert property (@(posedge mclk_i) disable iff (rst_i)
      rx_fin && mode == SPB_MODE1 && !ctrl_reg[SPB_B_SM2] |=> ctrl_reg[SPB_B_RB8] == $past(stop_ok))
      else $error("stop bit not stored");
   AST_TI_STOP: assert property (@(posedge mclk_i) disable iff (rst_i)
      ti_set && mode != SPB_MODE0 |=> txd_reg) else $error("stop level missing at transmit done");
endmodule
`default_nettype wire

/* File: sim/spb_far_node.sv */
// far serial node: drives the receive line and captures frames from the transmit line
// assumes an idle-high line and bit periods counted in clocks
`timescale 1ns/10ps
`default_nettype none
module spb_far_node (
   input  wire logic mclk_i,
   input  wire logic line_i,
   output var  logic line_o
);
   // pulled-up line idles high
   initial line_o = 1'b1;

   // start bit, data lsb first (ninth bit when nb is 9), then the stop level
   task automatic send(input logic [8:0] d, input int nb, input logic stop, input int p);
      @(posedge mclk_i);
      line_o <= 1'b0;
      repeat (p) @(posedge mclk_i);
      for (int i = 0; i < nb; i++) begin
         line_o <= d[i];
         repeat (p) @(posedge mclk_i);
      end
      line_o <= stop;
      repeat (p) @(posedge mclk_i);
      line_o <= 1'b1;
   endtask

   // samples each bit mid-period; bit nb of v is the stop bit
   task automatic capture(input int nb, input int p, output logic [9:0] v);
      int n;
      v = '1;
      for (n = 0; n < 4000 && line_i !== 1'b0; n++) @(posedge mclk_i);
      repeat (p / 2) @(posedge mclk_i);
      for (int i = 0; i <= nb; i++) begin
         repeat (p) @(posedge mclk_i);
         #1;
         v[i] = line_i;
      end
   endtask
endmodule
`default_nettype wire

/* File: sim/tb.sv */
// self-checking bench for the serial port core
// assumes the far node model and a 16x sample tick every 4 clocks (64-clock bits)
`timescale 1ns/10ps
`default_nettype none
module tb;
   import spb_pkg::*;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic        wr   = 1'b0;
   logic        rd   = 1'b0;
   logic        tick = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic        rxd;
   logic        sync_out;
   logic        sync_oe;
   logic        txd;
   logic        irq;
   logic [31:0] seed = 32'h697325AF;
   int          tc = 0;
   int          errors = 0;
   int          num_checks = 0;
   logic [7:0]  exp_q[$];

   spb_core spb_core_i (.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .baud_tick_i(tick), .rxd_i(rxd), .rxd_o(sync_out),
      .rxd_oe_o(sync_oe), .txd_o(txd), .irq_o(irq));
   spb_far_node node_i (.mclk_i(mclk), .line_i(txd), .line_o(rxd));

   initial begin
      forever #25 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      tc <= (tc + 1) % 4;
      tick <= (tc == 3);
   end

   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
      @(posedge mclk);
      #1;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic rx_frame(input logic [7:0] ctrl, input int nb, input logic ninth, input logic stop,
                           input logic exp_ri, input int exp_rb8);
      logic [7:0] d;
      logic [7:0] r;
      d = xs();
      wr_reg(SPB_ADDR_CTRL, ctrl);
      wr_reg(SPB_ADDR_STAT, 8'h07);
      if (exp_ri) exp_q.push_back(d);
      node_i.send({ninth, d}, nb, stop, 64);
      repeat (64) @(posedge mclk);
      rd_reg(SPB_ADDR_STAT, r);
      check(r[1], exp_ri);
      rd_reg(SPB_ADDR_CTRL, r);
      if (exp_rb8 >= 0) check(r[2], exp_rb8[0]);
      if (exp_ri) begin
         rd_reg(SPB_ADDR_DATA, r);
         check(r, exp_q.pop_front());
      end
   endtask

   task automatic tx_frame(input logic [7:0] ctrl, input int nb);
      logic [7:0] d;
      logic [9:0] v;
      d = xs();
      wr_reg(SPB_ADDR_CTRL, ctrl);
      wr_reg(SPB_ADDR_STAT, 8'h07);
      wr_reg(SPB_ADDR_MASK, 8'h01);
      check(irq, 1'b0);
      wr_reg(SPB_ADDR_DATA, d);
      check(sync_oe, 1'b0);
      node_i.capture(nb, 64, v);
      check(irq, 1'b1);
      check(v, (nb == 8) ? {2'b11, d} : {1'b1, ctrl[3], d});
      repeat (64) @(posedge mclk);
      wr_reg(SPB_ADDR_MASK, 8'h00);
      check(irq, 1'b0);
      wr_reg(SPB_ADDR_MASK, 8'h01);
      check(irq, 1'b1);
      wr_reg(SPB_ADDR_STAT, 8'h01);
      check(irq, 1'b0);
   endtask

   task automatic summarize();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   initial begin
      #3000000;
      errors++;
      summarize();
   end

   initial begin
      logic [7:0] r;
      logic [7:0] m0d;
      repeat (4) @(posedge mclk);
      rst <= 1'b0;
      rd_reg(SPB_ADDR_CTRL, r);
      check(r, 8'h00);
      rd_reg(8'h80, r);
      check(r, 8'h00);
      tx_frame(8'h50, 8);
      tx_frame(8'hC8, 9);
      tx_frame(8'h80, 9);
      rx_frame(8'h50, 8, 1'b0, 1'b1, 1'b1, 1);
      rx_frame(8'h40, 8, 1'b0, 1'b1, 1'b0, -1);
      rx_frame(8'h70, 8, 1'b0, 1'b0, 1'b0, -1);
      wr_reg(SPB_ADDR_AUX, 8'h01);
      rd_reg(SPB_ADDR_CTRL, r);
      check(r[7], 1'b1);
      rd_reg(SPB_ADDR_STAT, r);
      check(r[2], 1'b1);
      wr_reg(SPB_ADDR_STAT, 8'h04);
      rd_reg(SPB_ADDR_STAT, r);
      check(r[2], 1'b0);
      rd_reg(SPB_ADDR_CTRL, r);
      check(r[7], 1'b1);
      wr_reg(SPB_ADDR_CTRL, 8'h70);
      rd_reg(SPB_ADDR_CTRL, r);
      check(r[7], 1'b0);
      wr_reg(SPB_ADDR_AUX, 8'h00);
      rx_frame(8'hF0, 9, 1'b0, 1'b1, 1'b0, -1);
      rx_frame(8'hF0, 9, 1'b1, 1'b1, 1'b1, 1);
      rx_frame(8'h90, 9, 1'b0, 1'b1, 1'b1, 0);
      // mode 0 transmit: eight bits on the shared data line, 12 clocks each
      wr_reg(SPB_ADDR_CTRL, 8'h00);
      wr_reg(SPB_ADDR_STAT, 8'h07);
      m0d = xs();
      wr_reg(SPB_ADDR_DATA, m0d);
      check(sync_oe, 1'b1);
      repeat (5) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         #1;
         check(sync_out, m0d[i]);
         repeat (12) @(posedge mclk);
      end
      #1;
      check(sync_oe, 1'b0);
      rd_reg(SPB_ADDR_STAT, r);
      check(r[0], 1'b1);
      // mode 0 receive of an idle-high line
      wr_reg(SPB_ADDR_CTRL, 8'h10);
      repeat (120) @(posedge mclk);
      rd_reg(SPB_ADDR_STAT, r);
      check(r[1], 1'b1);
      rd_reg(SPB_ADDR_DATA, r);
      check(r, 8'hFF);
      summarize();
   end
endmodule
`default_nettype wire
